// ---- edge_event_pkg.sv ----
/*
 * Constants and carrier types for the edge event detector.
 * Assumes one 20 MHz system clock and an active-low asynchronous reset.
 */
package edge_event_pkg;

    // ==================================================================
    // Sizes
    localparam int NUM_LINES     = 18;
    localparam int NUM_EXT       = 16;
    localparam int NUM_PORTS     = 5;
    localparam int PINS_PER_PORT = 16;
    localparam int SEL_W         = 3;
    // Clock stages between a capture toggle and the edge strobe
    localparam int SYNC_STAGES   = 3;

    // ==================================================================
    // Values after reset
    localparam logic [NUM_LINES-1:0] PENDING_RESET = 18'h0_0000;
    localparam logic                 CAPTURE_RESET = 1'b0;

    // Per-line configuration, one bit per line in each field
    typedef struct packed {
        logic [NUM_LINES-1:0] rise_enable;
        logic [NUM_LINES-1:0] fall_enable;
        logic [NUM_LINES-1:0] irq_unmask;
        logic [NUM_LINES-1:0] event_unmask;
    } line_config_t;

endpackage

// ---- edge_event_detector.sv ----
/*
 * Edge event detector: 18 lines, 16 fed from selectable GPIO pins and
 * 2 from internal sources, each with its own trigger edges, masks and
 * pending bit. Assumes configuration inputs are held steady by the
 * surrounding logic and that the clear vector is a one-cycle write.
 *
 * Pin and internal lines may change at any time; they are never
 * sampled directly but clock their own capture toggles. Each toggle
 * is then brought into the system clock domain through a short
 * synchroniser, so a request appears about three clocks after the
 * line edge. A select change may itself look like an edge, so the
 * owner of the configuration masks a line before moving it.
 * Requests leave the block as registered levels and pulses only.
 */
`timescale 1ns/1ns
`default_nettype none

module edge_event_detector #(
    parameter int NUM_LINES = edge_event_pkg::NUM_LINES,
    parameter int NUM_EXT   = edge_event_pkg::NUM_EXT,
    parameter int NUM_PORTS = edge_event_pkg::NUM_PORTS
) (
    input  wire logic                                      clock_i,
    input  wire logic                                      resetn_i,
    input  wire logic [NUM_PORTS*edge_event_pkg::PINS_PER_PORT-1:0] gpio_i,
    input  wire logic [NUM_LINES-NUM_EXT-1:0]              internal_i,
    input  wire logic [NUM_EXT*edge_event_pkg::SEL_W-1:0]  port_select_i,
    input  wire edge_event_pkg::line_config_t              config_i,
    input  wire logic [NUM_LINES-1:0]                      pending_clear_i,
    output logic      [NUM_LINES-1:0]                      pending_o,
    output logic      [NUM_LINES-1:0]                      event_o,
    output logic                                           irq_o
);


    // ==================================================================
    // Local sizes
    localparam int PPP     = edge_event_pkg::PINS_PER_PORT;
    localparam int SEL_W   = edge_event_pkg::SEL_W;
    localparam int NUM_INT = NUM_LINES - NUM_EXT;
    localparam int SYNC_N  = edge_event_pkg::SYNC_STAGES;

    // ==================================================================
    // Decoding helpers

    // Port index picks the pin group, line index the pin inside it.
    // Codes past the last port give a quiet line, never an unknown.
    function automatic logic pick_pin(
        input logic [NUM_PORTS*PPP-1:0] pins,
        input logic [SEL_W-1:0]         sel,
        input int                       line_idx
    );
        logic result;
        result = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (int'(sel) == p) begin
                result = pins[p*PPP + line_idx];
            end
        end
        return result;
    endfunction

    // A toggle that moved between the two oldest stages is one edge
    function automatic logic toggle_moved(
        input logic [SYNC_N-1:0] sync
    );
        return sync[SYNC_N-1] ^ sync[SYNC_N-2];
    endfunction

    // ==================================================================
    // Internal signals
    logic [NUM_LINES-1:0] line;
    logic [NUM_LINES-1:0] rise_seen;
    logic [NUM_LINES-1:0] fall_seen;
    logic [NUM_LINES-1:0] rise_hit;
    logic [NUM_LINES-1:0] fall_hit;
    logic [NUM_LINES-1:0] trigger;
    logic [NUM_LINES-1:0] next_pending;
    logic [NUM_LINES-1:0] next_event;
    logic                 next_irq;

    genvar g;

    generate
        // ==============================================================
        // Line source selection
        for (g = 0; g < NUM_EXT; g++) begin : g_ext_mux
            logic [SEL_W-1:0] sel;

            assign sel     = port_select_i[g*SEL_W +: SEL_W];
            assign line[g] = pick_pin(gpio_i, sel, g);
        end

        // Internal sources take the lines above the pin-fed ones
        for (g = 0; g < NUM_INT; g++) begin : g_int_line
            assign line[NUM_EXT+g] = internal_i[g];
        end

        // ==============================================================
        // Edge capture
        // The line itself clocks a toggle flop, so a pulse narrower
        // than the system clock still flips it. Two edges of one kind
        // closer than about one clock merge into none.
        for (g = 0; g < NUM_LINES; g++) begin : g_capture
            logic              rise_tgl;
            logic              fall_tgl;
            logic [SYNC_N-1:0] rise_sync;
            logic [SYNC_N-1:0] fall_sync;

            // Rising edges of the line itself
            always_ff @(posedge line[g] or negedge resetn_i) begin
                if (!resetn_i) begin
                    rise_tgl <= edge_event_pkg::CAPTURE_RESET;
                end else begin
                    rise_tgl <= ~rise_tgl;
                end
            end

            // Falling edges of the line itself
            always_ff @(negedge line[g] or negedge resetn_i) begin
                if (!resetn_i) begin
                    fall_tgl <= edge_event_pkg::CAPTURE_RESET;
                end else begin
                    fall_tgl <= ~fall_tgl;
                end
            end

            // Rise toggle into the clock domain
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    rise_sync <= '0;
                end else begin
                    rise_sync <= {rise_sync[SYNC_N-2:0], rise_tgl};
                end
            end

            // Fall toggle into the clock domain
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    fall_sync <= '0;
                end else begin
                    fall_sync <= {fall_sync[SYNC_N-2:0], fall_tgl};
                end
            end

            assign rise_seen[g] = toggle_moved(rise_sync);
            assign fall_seen[g] = toggle_moved(fall_sync);
        end
    endgenerate

    // ==================================================================
    // Trigger selection and masking
    assign rise_hit = rise_seen & config_i.rise_enable;
    assign fall_hit = fall_seen & config_i.fall_enable;
    assign trigger  = rise_hit | fall_hit;

    // A new edge wins over a clear in the same cycle
    assign next_pending = (pending_o & ~pending_clear_i)
                        | (trigger & config_i.irq_unmask);

    assign next_event = trigger & config_i.event_unmask;

    // Taken from the next value so the request leaves with the bit
    assign next_irq = |next_pending;

    // ==================================================================
    // Pending register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending_o <= edge_event_pkg::PENDING_RESET;
        end else begin
            pending_o <= next_pending;
        end
    end

    // ==================================================================
    // Interrupt request
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // ==================================================================
    // Event pulses, one clock per trigger, never latched
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            event_o <= '0;
        end else begin
            event_o <= next_event;
        end
    end

endmodule // edge_event_detector

`default_nettype wire

// ---- edge_event_properties.sv ----
/* Port checker for the edge event detector.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker
module edge_event_checker #(
    parameter int NUM_LINES = 18
) (
    input wire logic                          clock_i,
    input wire logic                          resetn_i,
    input wire edge_event_pkg::line_config_t  config_i,
    input wire logic [NUM_LINES-1:0]          pending_clear_i,
    input wire logic [NUM_LINES-1:0]          pending_o,
    input wire logic [NUM_LINES-1:0]          event_o,
    input wire logic                          irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // An event on a line whose request was unmasked a cycle before
    sequence s_event_for_irq;
        (event_o & $past(config_i.irq_unmask)) != '0;
    endsequence
    a_irq_is_or: assert property (irq_o == |pending_o)
        else $error("irq differs from pending");
    a_pend_edge_on: assert property (
        (pending_o & ~$past(pending_o) & ~$past(config_i.rise_enable
        | config_i.fall_enable)) == '0)
        else $error("pending with no edge enabled");
    a_event_masked: assert property (
        (event_o & ~$past(config_i.event_unmask)) == '0)
        else $error("masked event raised");
    a_event_edge_on: assert property (
        (event_o & ~$past(config_i.rise_enable
        | config_i.fall_enable)) == '0)
        else $error("event with no edge enabled");
    a_pend_masked: assert property (
        (pending_o & ~$past(pending_o)
        & ~$past(config_i.irq_unmask)) == '0)
        else $error("masked line set pending");
    a_pend_sticky: assert property (
        ($past(pending_o) & ~pending_o & ~$past(pending_clear_i)) == '0)
        else $error("pending dropped without clear");
    a_event_sets_pend: assert property (
        (event_o & $past(config_i.irq_unmask) & ~pending_o) == '0)
        else $error("event without pending");
    a_irq_on_event: assert property (s_event_for_irq |-> irq_o)
        else $error("event without interrupt request");
endmodule // edge_event_checker
bind edge_event_detector edge_event_checker #(.NUM_LINES(NUM_LINES))
    i_edge_event_checker (.clock_i, .resetn_i, .config_i, .pending_clear_i,
    .pending_o, .event_o, .irq_o);
`default_nettype wire

// ---- line_source.sv ----
/* Far-side model: pin and internal source levels with short blips.
   Assumes the bench drives level and blip at the rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Line source
module line_source (
    input  wire logic        clock_i,
    input  wire logic [81:0] level_i,
    input  wire logic [81:0] blip_i,
    output logic      [81:0] lines_o
);
    logic [81:0] flip = '0;
    // 10 ns blip, well inside one clock period, so sampling would miss it
    always @(posedge clock_i) begin
        #10 flip = blip_i;
        #10 flip = '0;
    end
    assign lines_o = level_i ^ flip;
endmodule // line_source
`default_nettype wire

// ---- edge_event_detector_tb.sv ----
/* Testbench for the edge event detector.
   Assumes the line_source model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module edge_event_detector_tb;
    logic                         clock_i = 1'b0;
    logic                         resetn_i = 1'b0;
    logic [47:0]                  sel = 48'h0000_0000_0000;
    edge_event_pkg::line_config_t cfg = '0;
    logic [17:0]                  clr = 18'h0_0000;
    logic [81:0]                  lvl = '0;
    logic [81:0]                  blip = '0;
    wire logic [81:0]             lines;
    logic [17:0]                  pending_o;
    logic [17:0]                  event_o;
    logic                         irq_o;
    int                           num_errors = 0;
    int                           tests_run = 0;
    line_source i_line_source (.clock_i, .level_i(lvl), .blip_i(blip),
        .lines_o(lines));
    edge_event_detector i_edge_event_detector (.clock_i, .resetn_i,
        .gpio_i(lines[79:0]), .internal_i(lines[81:80]), .port_select_i(sel),
        .config_i(cfg), .pending_clear_i(clr), .pending_o, .event_o, .irq_o);
    initial forever #25 clock_i = ~clock_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Sample 1 ns after the edge so its updates have landed
    task automatic chk(input logic ok, input string m);
        #1;
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic clear(input logic [17:0] v);
        tick(1);
        clr <= v;
        tick(1);
        clr <= 18'h0_0000;
        tick(1);
    endtask
    task automatic t_pin;
        tick(1);
        sel[11:9] <= 3'h2;
        cfg.rise_enable <= 18'h0_0008;
        cfg.irq_unmask <= 18'h3_ffff;
        cfg.event_unmask <= 18'h3_ffff;
        blip[35] <= 1'b1;
        tick(1);
        blip[35] <= 1'b0;
        tick(6);
        chk(pending_o === 18'h0_0008 && irq_o === 1'b1, "blip missed");
        clear(18'h3_fff7);
        chk(pending_o === 18'h0_0008, "zero bits cleared");
        clear(18'h0_0008);
        chk(pending_o === 18'h0_0000 && irq_o === 1'b0, "no clear");
    endtask
    task automatic t_mask;
        tick(1);
        sel[5:3] <= 3'h5;
        sel[8:6] <= 3'h4;
        cfg.rise_enable <= 18'h0_000e;
        cfg.irq_unmask <= 18'h3_fff7;
        blip[35] <= 1'b1;
        blip[19] <= 1'b1;
        blip[1] <= 1'b1;
        blip[66] <= 1'b1;
        tick(1);
        blip <= '0;
        tick(6);
        chk(pending_o === 18'h0_0004, "mask or select wrong");
        clear(18'h0_0004);
        chk(pending_o === 18'h0_0000, "port 4 line not cleared");
        tick(1);
        cfg.irq_unmask <= 18'h3_ffff;
    endtask
    task automatic t_reset;
        tick(1);
        lvl[81] <= 1'b1;
        tick(6);
        chk(pending_o[17] === 1'b1, "rise before reset");
        tick(1);
        resetn_i <= 1'b0;
        tick(2);
        chk(pending_o === 18'h0_0000 && irq_o === 1'b0, "mid reset");
        tick(1);
        resetn_i <= 1'b1;
        tick(3);
        chk(pending_o === 18'h0_0000, "false edge after reset");
        tick(1);
        lvl[81] <= 1'b0;
        tick(6);
        chk(pending_o[17] === 1'b1, "fall after reset");
        clear(18'h2_0000);
    endtask
    task automatic t_modes;
        int cnt;
        for (int m = 0; m < 4; m++) begin
            cnt = 0;
            tick(1);
            cfg.rise_enable[17] <= m[0];
            cfg.fall_enable[17] <= m[1];
            tick(2);
            lvl[81] <= 1'b1;
            for (int i = 0; i < 20; i++) begin
                tick(1);
                if (i == 10) lvl[81] <= 1'b0;
                #1 cnt += (event_o[17] === 1'b1);
            end
            chk(cnt == m[0] + m[1], "edge count wrong");
            chk(pending_o[17] === (m != 0), "internal pending wrong");
            clear(18'h2_0000);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(12);
        resetn_i <= 1'b1;
        tick(2);
        chk(pending_o === 18'h0_0000 && event_o === 18'h0_0000, "reset");
        t_pin;
        t_mask;
        t_modes;
        t_reset;
        wrap_up;
    end
endmodule // edge_event_detector_tb
`default_nettype wire
